// *** dl_msg_pkg.sv ***
// Shared constants for the T1 data link message control block
package dl_msg_pkg;
   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_RPT_CTRL = 10'h07F;
   localparam logic [9:0] IDX_TX_CODE  = 10'h080;
   localparam logic [9:0] IDX_RX_CTRL  = 10'h081;
   localparam logic [9:0] IDX_RX_FLAG  = 10'h082;
   localparam logic [9:0] IDX_RX_CODE  = 10'h083;
   localparam logic [9:0] IDX_TX_EN    = 10'h084;
   localparam logic [9:0] IDX_FORMAT   = 10'h085;
   localparam logic [9:0] IDX_TX2_ASG  = 10'h086;
   localparam logic [9:0] IDX_TX3_ASG  = 10'h087;
   localparam logic [9:0] IDX_TX2_BITS = 10'h089;
   localparam logic [9:0] IDX_TX3_BITS = 10'h08A;
   // Field positions
   localparam int RPT_EN_POS    = 0;
   localparam int IRQ_EN_POS    = 0;
   localparam int VAL_SEL_POS   = 1;
   localparam int FMT_ESF_POS   = 0;
   localparam int FMT_DM_POS    = 1;
   localparam int ASG_EVEN_POS  = 6;
   localparam int ASG_ODD_POS   = 5;
   // Reset values
   localparam logic [5:0] CODE_ONES  = 6'h3F;
   localparam logic [5:0] RPT_RESET  = 6'h00;
   localparam logic [6:0] ASG_RESET  = 7'h00;
   localparam logic [7:0] BITS_RESET = 8'h00;
   // Message pattern and last channel index
   localparam logic [7:0] MSG_FLAG    = 8'hFE;
   localparam logic [3:0] MSG_LAST    = 4'hE;
   localparam logic [4:0] LAST_CHAN   = 5'h17;
   // Validation windows and thresholds
   localparam logic [3:0] WIN_LONG_THR  = 4'h8;
   localparam logic [3:0] WIN_SHORT_THR = 4'h4;
   localparam int HIST_DEPTH = 10;
   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Timing
   localparam int CLK_HZ         = 40_000_000;
   localparam int REPORT_MS      = 1000;
   localparam int REPORT_CYCLES  = (CLK_HZ / 1000) * REPORT_MS;
endpackage

// *** dl_msg_ctrl.sv ***
// Data link message control: report timer, message send and receive, HDLC tx steering
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
module dl_msg_ctrl
   import dl_msg_pkg::*;
#(
   parameter int REPORT_PERIOD = REPORT_CYCLES
) (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   input  wire logic [11:0] s_axi_awaddr_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   output logic [1:0]       s_axi_bresp_o,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   input  wire logic [11:0] s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   input  wire logic        dl_strobe_i,
   input  wire logic        rx_dl_bit_i,
   input  wire logic        frame_odd_i,
   input  wire logic [4:0]  channel_i,
   input  wire logic [2:0]  bit_index_i,
   output logic             tx_dl_bit_o,
   output logic             tx_msg_active_o,
   output logic             report_req_o,
   output logic [4:0]       report_fields_o,
   output logic [2:0]       hdlc_tx_en_o,
   output logic [1:0]       hdlc_insert_o,
   output logic             irq_o
);

   typedef struct packed {
      logic                             awready;
      logic                             wready;
      logic [9:0]                       aw_idx;
      logic                             aw_hi;
      logic [7:0]                       w_data;
      logic                             w_strb;
      logic                             bvalid;
      logic [1:0]                       bresp;
      logic                             arready;
      logic                             rvalid;
      logic [7:0]                       rdata;
      logic [1:0]                       rresp;
      logic [5:0]                       rpt_ctrl;
      logic [5:0]                       tx_code;
      logic [1:0]                       rx_ctrl;
      logic                             flag;
      logic [5:0]                       rx_code;
      logic [2:0]                       tx_en;
      logic [1:0]                       fmt;
      logic [1:0][6:0]                  asg;
      logic [1:0][7:0]                  bitsel;
      logic [25:0]                      sec_cnt;
      logic                             report_req;
      logic [4:0]                       report_fields;
      logic [3:0]                       tx_pos;
      logic                             tx_active;
      logic [5:0]                       tx_latched;
      logic                             tx_bit;
      logic [14:0]                      rx_shift;
      logic [HIST_DEPTH-2:0][5:0]       hist;
      logic [HIST_DEPTH-2:0]            hist_valid;
      logic                             irq;
      logic [2:0]                       en_out;
      logic [1:0]                       ins;
   } state_t;

   state_t s;
   state_t next_s;

   logic                  esf;
   logic                  do_wr;
   logic                  wr_flag_clr;
   logic [14:0]           rx_next_shift;
   logic                  rx_match;
   logic [5:0]            rx_cand;
   logic [HIST_DEPTH-2:0] hist_eq;
   logic [3:0]            same_cnt;
   logic                  declare;
   logic [1:0]            ins_hit;

   assign esf = s.fmt[FMT_ESF_POS];

   // Write happens once both halves are held and the last response is gone
   assign do_wr = !s.awready && !s.wready && !s.bvalid;
   assign wr_flag_clr = do_wr && !s.aw_hi && (s.aw_idx == IDX_RX_FLAG) && s.w_strb
                        && s.w_data[0];

   // Received pattern sits oldest bit first at the top of the shift window
   assign rx_next_shift = {s.rx_shift[13:0], rx_dl_bit_i};
   assign rx_match = dl_strobe_i && esf && (rx_next_shift[14:7] == MSG_FLAG)
                     && !rx_next_shift[0];
   assign rx_cand = rx_next_shift[6:1];

   // Compare the candidate with each earlier reception in the history
   generate
      for (genvar i = 0; i < HIST_DEPTH - 1; i++) begin : g_hist
         assign hist_eq[i] = s.hist_valid[i] && (s.hist[i] == rx_cand);
      end
   endgenerate

   // Count includes the newest reception itself; window is 10 or 5 deep
   always_comb begin
      logic [3:0] cnt;
      cnt = 4'h1;
      for (int i = 0; i < HIST_DEPTH - 1; i++) begin
         if (hist_eq[i] && (!s.rx_ctrl[VAL_SEL_POS] || i < 4)) begin
            cnt = cnt + 4'h1;
         end
      end
      same_cnt = cnt;
   end

   // Declared only on a fresh code, so a held message raises the flag once
   assign declare = rx_match && (rx_cand != s.rx_code)
                    && (same_cnt >= (s.rx_ctrl[VAL_SEL_POS] ? WIN_SHORT_THR
                                                           : WIN_LONG_THR));

   // Insertion gate for HDLC transmitters 2 and 3; out-of-range channels never match
   generate
      for (genvar j = 0; j < 2; j++) begin : g_ins
         assign ins_hit[j] = s.tx_en[j+1]
                             && (frame_odd_i ? s.asg[j][ASG_ODD_POS]
                                             : s.asg[j][ASG_EVEN_POS])
                             && (s.asg[j][4:0] <= LAST_CHAN)
                             && (s.asg[j][4:0] == channel_i)
                             && s.bitsel[j][3'h7 - bit_index_i];
      end
   endgenerate

   // Message bit at a given position of the 15-bit pattern
   function automatic logic msg_bit(input logic [5:0] code, input logic [3:0] pos);
      logic b;
      b = 1'b0;
      if (pos < 4'h7) begin
         b = 1'b1;
      end else if (pos >= 4'h8 && pos <= 4'hD) begin
         b = code[3'(pos - 4'h8)];
      end
      return b;
   endfunction

   // Register read mux; reserved bits and unmapped words read zero
   function automatic logic [7:0] rd_reg(input state_t st, input logic [9:0] idx);
      logic [7:0] v;
      v = 8'h00;
      unique case (idx)
         IDX_RPT_CTRL: v = {2'h0, st.rpt_ctrl};
         IDX_TX_CODE:  v = {2'h0, st.tx_code};
         IDX_RX_CTRL:  v = {6'h00, st.rx_ctrl};
         IDX_RX_FLAG:  v = {7'h00, st.flag};
         IDX_RX_CODE:  v = {2'h0, st.rx_code};
         IDX_TX_EN:    v = {5'h00, st.tx_en};
         IDX_FORMAT:   v = {6'h00, st.fmt};
         IDX_TX2_ASG:  v = {1'b0, st.asg[0]};
         IDX_TX3_ASG:  v = {1'b0, st.asg[1]};
         IDX_TX2_BITS: v = st.bitsel[0];
         IDX_TX3_BITS: v = st.bitsel[1];
         default:      v = 8'h00;
      endcase
      return v;
   endfunction

   function automatic logic mapped(input logic [9:0] idx);
      return idx inside {IDX_RPT_CTRL, IDX_TX_CODE, IDX_RX_CTRL, IDX_RX_FLAG,
                         IDX_RX_CODE, IDX_TX_EN, IDX_FORMAT, IDX_TX2_ASG,
                         IDX_TX3_ASG, IDX_TX2_BITS, IDX_TX3_BITS};
   endfunction

   // Next-state logic for bus, registers, timers and message engines
   always_comb begin
      next_s = s;
      next_s.report_req = 1'b0;

      // Address and data may arrive in either order
      if (s_axi_awvalid_i && s.awready) begin
         next_s.aw_idx  = s_axi_awaddr_i[11:2];
         next_s.aw_hi   = 1'b0;
         next_s.awready = 1'b0;
      end
      if (s_axi_wvalid_i && s.wready) begin
         next_s.w_data = s_axi_wdata_i[7:0];
         next_s.w_strb = s_axi_wstrb_i[0];
         next_s.wready = 1'b0;
      end
      if (s.bvalid && s_axi_bready_i) begin
         next_s.bvalid  = 1'b0;
         next_s.awready = 1'b1;
         next_s.wready  = 1'b1;
      end
      if (do_wr) begin
         next_s.bvalid = 1'b1;
         next_s.bresp  = mapped(s.aw_idx) ? RESP_OKAY : RESP_SLVERR;
         // Only byte lane 0 carries register bits
         if (s.w_strb) begin
            unique case (s.aw_idx)
               IDX_RPT_CTRL: next_s.rpt_ctrl = s.w_data[5:0];
               IDX_TX_CODE:  next_s.tx_code  = s.w_data[5:0];
               IDX_RX_CTRL:  next_s.rx_ctrl  = s.w_data[1:0];
               IDX_TX_EN:    next_s.tx_en    = s.w_data[2:0];
               IDX_FORMAT:   next_s.fmt      = s.w_data[1:0];
               IDX_TX2_ASG:  next_s.asg[0]   = s.w_data[6:0];
               IDX_TX3_ASG:  next_s.asg[1]   = s.w_data[6:0];
               IDX_TX2_BITS: next_s.bitsel[0] = s.w_data;
               IDX_TX3_BITS: next_s.bitsel[1] = s.w_data;
               default:      next_s.rpt_ctrl = s.rpt_ctrl;
            endcase
         end
      end

      // Read path: one outstanding read, answer one cycle after acceptance
      if (s.rvalid && s_axi_rready_i) begin
         next_s.rvalid  = 1'b0;
         next_s.arready = 1'b1;
      end
      if (s_axi_arvalid_i && s.arready) begin
         next_s.arready = 1'b0;
         next_s.rvalid  = 1'b1;
         next_s.rdata   = rd_reg(s, s_axi_araddr_i[11:2]);
         next_s.rresp   = mapped(s_axi_araddr_i[11:2]) ? RESP_OKAY : RESP_SLVERR;
      end

      // One-second report timer, held at zero while reporting is off
      if (esf && s.rpt_ctrl[RPT_EN_POS]) begin
         if (s.sec_cnt == 26'(REPORT_PERIOD - 1)) begin
            next_s.sec_cnt       = 26'h0;
            next_s.report_req    = 1'b1;
            next_s.report_fields = s.rpt_ctrl[5:1];
         end else begin
            next_s.sec_cnt = s.sec_cnt + 26'h1;
         end
      end else begin
         next_s.sec_cnt = 26'h0;
      end

      // Message sender; code choice is made only at a pattern boundary
      if (dl_strobe_i) begin
         if (s.tx_pos == 4'h0) begin
            if (esf && s.tx_code != CODE_ONES) begin
               next_s.tx_active  = 1'b1;
               next_s.tx_latched = s.tx_code;
               next_s.tx_bit     = 1'b1;
               next_s.tx_pos     = 4'h1;
            end else begin
               next_s.tx_active = 1'b0;
               next_s.tx_bit    = 1'b0;
            end
         end else begin
            next_s.tx_bit = msg_bit(s.tx_latched, s.tx_pos);
            next_s.tx_pos = (s.tx_pos == MSG_LAST) ? 4'h0 : s.tx_pos + 4'h1;
         end
      end

      // Message receiver history; cleared outside ESF
      if (!esf) begin
         next_s.hist_valid = '0;
      end else if (dl_strobe_i) begin
         next_s.rx_shift = rx_next_shift;
         if (rx_match) begin
            next_s.hist       = {s.hist[HIST_DEPTH-3:0], rx_cand};
            next_s.hist_valid = {s.hist_valid[HIST_DEPTH-3:0], 1'b1};
         end
      end
      if (declare) begin
         next_s.rx_code = rx_cand;
      end

      // Hardware set wins over a software clear in the same cycle
      next_s.flag = (s.flag && !wr_flag_clr) || declare;

      // Registered outputs
      next_s.irq       = next_s.flag && next_s.rx_ctrl[IRQ_EN_POS];
      next_s.en_out[0] = next_s.tx_en[0] && (next_s.fmt != 2'h0);
      next_s.en_out[2:1] = next_s.tx_en[2:1];
      next_s.ins       = ins_hit;
   end

   // State register
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s <= '0;
         s.awready  <= 1'b1;
         s.wready   <= 1'b1;
         s.arready  <= 1'b1;
         s.rpt_ctrl <= RPT_RESET;
         s.tx_code  <= CODE_ONES;
         s.rx_code  <= CODE_ONES;
         s.asg      <= {ASG_RESET, ASG_RESET};
         s.bitsel   <= {BITS_RESET, BITS_RESET};
      end else begin
         s <= next_s;
      end
   end

   assign s_axi_awready_o = s.awready;
   assign s_axi_wready_o  = s.wready;
   assign s_axi_bvalid_o  = s.bvalid;
   assign s_axi_bresp_o   = s.bresp;
   assign s_axi_arready_o = s.arready;
   assign s_axi_rvalid_o  = s.rvalid;
   assign s_axi_rresp_o   = s.rresp;
   assign s_axi_rdata_o   = {24'h000000, s.rdata};
   assign tx_dl_bit_o     = s.tx_bit;
   assign tx_msg_active_o = s.tx_active;
   assign report_req_o    = s.report_req;
   assign report_fields_o = s.report_fields;
   assign hdlc_tx_en_o    = s.en_out;
   assign hdlc_insert_o   = s.ins;
   assign irq_o           = s.irq;

   // Checks on the design's own outputs and internal registers
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_msg_start;
      dl_strobe_i && (s.tx_pos == 4'h0) && esf && (s.tx_code != CODE_ONES);
   endsequence

   sequence s_msg_flag_out;
      tx_msg_active_o && tx_dl_bit_o && (s.tx_pos == 4'h1);
   endsequence

   a_report_off: assert property (!(esf && s.rpt_ctrl[RPT_EN_POS]) |=> !report_req_o)
      else $error("report request while reporting disabled");
   a_report_gap: assert property (report_req_o |=> !report_req_o [*8])
      else $error("report requests too close together");
   a_report_bits: assert property (report_req_o
                                   |-> report_fields_o == $past(s.rpt_ctrl[5:1]))
      else $error("report fields differ from control bits");
   a_msg_starts: assert property (s_msg_start |=> s_msg_flag_out)
      else $error("message did not start with flag bit");
   a_msg_zero: assert property (dl_strobe_i && s.tx_active && s.tx_pos == 4'h7
                                |=> !tx_dl_bit_o)
      else $error("flag closing zero missing");
   a_msg_idle: assert property (dl_strobe_i && s.tx_pos == 4'h0 && s.tx_code == CODE_ONES
                                |=> !tx_msg_active_o)
      else $error("message sent with all ones code");
   a_flag_load: assert property (declare |=> s.flag && (s.rx_code == $past(rx_cand)))
      else $error("declared code not loaded");
   a_flag_clear: assert property (s.flag && wr_flag_clr && !declare |=> !s.flag)
      else $error("write one did not clear flag");
   a_flag_quiet: assert property (!s.flag && !declare |=> !s.flag)
      else $error("flag set without update");
   a_irq_follow: assert property (irq_o == (s.flag && s.rx_ctrl[IRQ_EN_POS]))
      else $error("interrupt output mismatch");
   // Enable output and format register load at the same edge, so compare in one cycle
   a_tx1_format: assert property (s.fmt == 2'h0 |-> !hdlc_tx_en_o[0])
      else $error("transmitter 1 enabled outside ESF and DM");
   a_insert_gate: assert property (hdlc_insert_o[0] |-> $past(s.tx_en[1])
                                   && ($past(s.asg[0][6:5]) != 2'h0))
      else $error("insertion without enable or frame select");
   a_declare_new: assert property (declare |=> s.rx_code != $past(s.rx_code))
      else $error("repeated code declared");

endmodule

// *** dl_far_end.sv ***
// Remote line terminal model: sends data link messages and collects sent bits
`timescale 1ns/1ps
module dl_far_end (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   input  wire logic        send_i,
   input  wire logic [5:0]  code_i,
   input  wire logic        tx_bit_i,
   output logic             dl_strobe_o,
   output logic             rx_bit_o,
   output logic [14:0]      tx_hist_o,
   output logic [7:0]       n_sent_o
);
   logic [1:0]  cnt;
   logic [3:0]  pos;
   logic        last;
   logic        strobe_d;
   logic        cur;
   logic [14:0] pat;
   // Flag, code bits 0 to 5, closing zero; idle line carries ones
   assign pat = {8'hFE, code_i[0], code_i[1], code_i[2], code_i[3], code_i[4], code_i[5],
                 1'h0};
   assign cur = send_i ? pat[4'hE - pos] : 1'h1;
   assign dl_strobe_o = (cnt == 2'h3);
   // Off the strobe the line shows the inverse, so a stale bit never passes
   assign rx_bit_o = dl_strobe_o ? cur : ~last;
   // Strobe every fourth cycle; sent bit is taken the cycle after the strobe
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt <= 2'h0;
         pos <= 4'h0;
         last <= 1'h0;
         strobe_d <= 1'h0;
         tx_hist_o <= 15'h0000;
         n_sent_o <= 8'h00;
      end else begin
         cnt <= cnt + 2'h1;
         strobe_d <= dl_strobe_o;
         if (strobe_d) begin
            tx_hist_o <= {tx_hist_o[13:0], tx_bit_i};
         end
         if (dl_strobe_o) begin
            last <= cur;
            pos <= (pos == 4'hE) ? 4'h0 : pos + 4'h1;
            if (send_i && pos == 4'hE) begin
               n_sent_o <= n_sent_o + 8'h01;
            end
         end
         // Dropping send restarts the pattern and the count
         if (!send_i) begin
            pos <= 4'h0;
            n_sent_o <= 8'h00;
         end
      end
   end
endmodule

// *** dl_msg_ctrl_test.sv ***
// Self-checking bench for the data link message control block
`timescale 1ns/1ps
module dl_msg_ctrl_test;
   import dl_msg_pkg::*;
   localparam int PERIOD = 20;
   logic        ref_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, strobe, rx_bit, frame_odd;
   logic        tx_bit, msg_active, report_req, irq, send;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp, insert;
   logic [4:0]  channel, fields;
   logic [2:0]  bit_index, tx_en;
   logic [5:0]  send_code;
   logic [14:0] tx_hist;
   logic [7:0]  n_sent;
   int          n_mismatch, comparisons;
   dl_msg_ctrl #(.REPORT_PERIOD(PERIOD)) dl_msg_ctrl_i (.ref_clk_i(ref_clk), .rst_i(rst),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .dl_strobe_i(strobe),
      .rx_dl_bit_i(rx_bit), .frame_odd_i(frame_odd), .channel_i(channel),
      .bit_index_i(bit_index), .tx_dl_bit_o(tx_bit), .tx_msg_active_o(msg_active),
      .report_req_o(report_req), .report_fields_o(fields), .hdlc_tx_en_o(tx_en),
      .hdlc_insert_o(insert), .irq_o(irq));
   dl_far_end dl_far_end_i (.ref_clk_i(ref_clk), .rst_i(rst), .send_i(send),
      .code_i(send_code), .tx_bit_i(tx_bit), .dl_strobe_o(strobe), .rx_bit_o(rx_bit),
      .tx_hist_o(tx_hist), .n_sent_o(n_sent));
   // 40 MHz clock
   initial begin
      ref_clk = 1'h0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task automatic print_verdict;
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic give_up(input string what);
      n_mismatch++;
      $display("unexpected at %0t: no answer on %s", $time, what);
      print_verdict();
   endtask
   // Ready is looked at on the falling edge, where registered outputs have settled
   task automatic wr(input logic [9:0] idx, input logic [7:0] d, output logic [1:0] resp);
      logic ta, tw, done;
      done = 1'h0;
      @(posedge ref_clk);
      awaddr <= {idx, 2'h0};
      wdata <= {24'h000000, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (int i = 0; i < 50 && !done; i++) begin
         @(negedge ref_clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         done = bvalid;
         resp = bresp;
         @(posedge ref_clk);
         if (ta) awvalid <= 1'h0;
         if (tw) wvalid <= 1'h0;
         if (done) bready <= 1'h0;
      end
      if (!done) give_up("write");
   endtask
   task automatic rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] resp);
      logic ta, done;
      done = 1'h0;
      @(posedge ref_clk);
      araddr <= {idx, 2'h0};
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (int i = 0; i < 50 && !done; i++) begin
         @(negedge ref_clk);
         ta = arvalid && arready;
         done = rvalid;
         d = rdata;
         resp = rresp;
         @(posedge ref_clk);
         if (ta) arvalid <= 1'h0;
         if (done) rready <= 1'h0;
      end
      if (!done) give_up("read");
   endtask
   task automatic wrx(input logic [9:0] idx, input logic [7:0] d);
      logic [1:0] r;
      wr(idx, d, r);
      chk({30'h0, r}, {30'h0, RESP_OKAY}, "write response");
   endtask
   task automatic rdchk(input logic [9:0] idx, input logic [7:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      rd(idx, d, r);
      chk(d, {24'h000000, exp}, "read data");
   endtask
   task automatic regs_scn;
      logic [9:0]  idx [11] = '{10'h07F, 10'h080, 10'h081, 10'h082, 10'h083, 10'h084,
                                10'h085, 10'h086, 10'h087, 10'h089, 10'h08A};
      logic [7:0]  rv [11] = '{8'h00, 8'h3F, 8'h00, 8'h00, 8'h3F, 8'h00, 8'h00, 8'h00,
                               8'h00, 8'h00, 8'h00};
      logic [31:0] d;
      logic [1:0]  r;
      for (int i = 0; i < 11; i++) rdchk(idx[i], rv[i]);
      rd(10'h088, d, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
      wr(10'h088, 8'h55, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
      wrx(IDX_RX_CODE, 8'h00);
      rdchk(IDX_RX_CODE, 8'h3F);
      wrx(IDX_TX3_BITS, 8'hA5);
      rdchk(IDX_TX3_BITS, 8'hA5);
   endtask
   task automatic hdlc_en_scn;
      wrx(IDX_TX_EN, 8'h07);
      @(negedge ref_clk);
      chk({29'h0, tx_en}, 32'h6, "tx enables, no format");
      wrx(IDX_FORMAT, 8'h02);
      @(negedge ref_clk);
      chk({29'h0, tx_en}, 32'h7, "tx enables, DM");
      wrx(IDX_TX_EN, 8'h02);
      @(negedge ref_clk);
      chk({29'h0, tx_en}, 32'h2, "tx2 only");
   endtask
   task automatic ins(input logic o, input logic [4:0] c, input logic [2:0] b,
                      input logic [1:0] e);
      @(posedge ref_clk);
      frame_odd <= o;
      channel <= c;
      bit_index <= b;
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk({30'h0, insert}, {30'h0, e}, "insert");
   endtask
   // Tx2 owns channel 24 first bit in even frames, tx3 channel 1 last bit in odd
   task automatic insert_scn;
      wrx(IDX_TX_EN, 8'h06);
      wrx(IDX_TX2_ASG, 8'h57);
      wrx(IDX_TX2_BITS, 8'h80);
      wrx(IDX_TX3_ASG, 8'h20);
      wrx(IDX_TX3_BITS, 8'h01);
      ins(1'h0, 5'h17, 3'h0, 2'h1);
      ins(1'h1, 5'h17, 3'h0, 2'h0);
      ins(1'h0, 5'h17, 3'h1, 2'h0);
      ins(1'h0, 5'h16, 3'h0, 2'h0);
      ins(1'h1, 5'h00, 3'h7, 2'h2);
      ins(1'h0, 5'h00, 3'h7, 2'h0);
      wrx(IDX_TX2_ASG, 8'h17);
      ins(1'h0, 5'h17, 3'h0, 2'h0);
      wrx(IDX_TX2_ASG, 8'h57);
      wrx(IDX_TX_EN, 8'h04);
      ins(1'h0, 5'h17, 3'h0, 2'h0);
   endtask
   task automatic pulses(output int n);
      n = 0;
      for (int i = 0; i < 60; i++) begin
         @(negedge ref_clk);
         if (report_req === 1'h1) n++;
      end
   endtask
   task automatic report_scn;
      int i, n;
      wrx(IDX_FORMAT, 8'h01);
      wrx(IDX_RPT_CTRL, 8'h2B);
      @(negedge ref_clk);
      for (i = 0; i < 100 && report_req !== 1'h1; i++) @(negedge ref_clk);
      if (i == 100) give_up("report");
      chk({27'h0, fields}, 32'h15, "report fields");
      @(negedge ref_clk);
      for (n = 1; n < 100 && report_req !== 1'h1; n++) @(negedge ref_clk);
      chk(n, PERIOD, "report spacing");
      wrx(IDX_RPT_CTRL, 8'h2A);
      pulses(n);
      chk(n, 0, "reports while disabled");
      wrx(IDX_FORMAT, 8'h00);
      wrx(IDX_RPT_CTRL, 8'h2B);
      pulses(n);
      chk(n, 0, "reports outside ESF");
      wrx(IDX_RPT_CTRL, 8'h00);
   endtask
   task automatic tx_scn;
      logic [5:0]  c;
      logic [14:0] e;
      int          i;
      c = 6'h2D;
      e = {8'hFE, c[0], c[1], c[2], c[3], c[4], c[5], 1'h0};
      wrx(IDX_FORMAT, 8'h01);
      wrx(IDX_TX_CODE, {2'h0, c});
      for (i = 0; i < 400 && tx_hist !== e; i++) @(negedge ref_clk);
      chk({17'h0, tx_hist}, {17'h0, e}, "sent pattern");
      chk({31'h0, msg_active}, 32'h1, "sender active");
      wrx(IDX_TX_CODE, 8'h3F);
      for (i = 0; i < 400 && (msg_active !== 1'h0 || tx_hist !== 15'h0); i++) begin
         @(negedge ref_clk);
      end
      chk({16'h0, msg_active, tx_hist}, 32'h0, "sender idle");
   endtask
   // Poll the flag, then check count of receptions and the stored code
   task automatic wait_msg(input logic [7:0] n, input logic [5:0] c);
      logic [31:0] d;
      logic [1:0]  r;
      d = 32'h0;
      for (int i = 0; i < 300 && d[0] !== 1'h1; i++) rd(IDX_RX_FLAG, d, r);
      if (d[0] !== 1'h1) give_up("message");
      chk({24'h0, n_sent}, {24'h0, n}, "receptions before declare");
      rdchk(IDX_RX_CODE, {2'h0, c[0], c[1], c[2], c[3], c[4], c[5]});
   endtask
   task automatic rx_scn;
      wrx(IDX_RX_CTRL, 8'h03);
      @(posedge ref_clk);
      send_code <= 6'h0B;
      send <= 1'h1;
      wait_msg(8'h04, 6'h0B);
      chk({31'h0, irq}, 32'h1, "irq with enable");
      wrx(IDX_RX_FLAG, 8'h00);
      rdchk(IDX_RX_FLAG, 8'h01);
      wrx(IDX_RX_FLAG, 8'h01);
      rdchk(IDX_RX_FLAG, 8'h00);
      chk({31'h0, irq}, 32'h0, "irq after clear");
      for (int i = 0; i < 900 && n_sent < 8'h09; i++) @(negedge ref_clk);
      if (n_sent < 8'h09) give_up("receptions");
      rdchk(IDX_RX_FLAG, 8'h00);
      wrx(IDX_RX_CTRL, 8'h00);
      @(posedge ref_clk);
      send <= 1'h0;
      repeat (120) @(posedge ref_clk);
      send_code <= 6'h32;
      send <= 1'h1;
      wait_msg(8'h08, 6'h32);
      chk({31'h0, irq}, 32'h0, "irq without enable");
   endtask
   initial begin
      n_mismatch = 0;
      comparisons = 0;
      rst = 1'h1;
      {awvalid, wvalid, bready, arvalid, rready, send, frame_odd} = 7'h00;
      {awaddr, araddr, wdata} = 56'h0;
      {channel, bit_index, send_code} = 14'h0000;
      repeat (3) @(posedge ref_clk);
      rst <= 1'h0;
      regs_scn();
      hdlc_en_scn();
      insert_scn();
      report_scn();
      tx_scn();
      rx_scn();
      print_verdict();
   end
endmodule
